// >>> verilog/gcrc_top.v
`timescale 1ns/10ps
`include "gcrc_consts.vh"

// How it works
// - Request wakes source, then unit, then route
// - Keep-alive keeps unit clock on pin
// - Standby without keep-alive freezes pin at off level
// - Synchronizing writes set busy at once, clear later
// - Second synchronizing write while busy stalls bus
// - Control, unit setup and ratio writes synchronize
// - Byte, halfword and word lanes all writable
// - Writing zero to soft reset starts no reset, only sets busy
// - Soft reset restores all but locked routes and their non-zero units
// - Soft reset and busy clear when done
// - Lock blocks route, unit and ratio writes
// - Unit zero can never be locked
// - Route enable gates the channel clock
// - Unit select picks units zero to eight
// - Target index picks the channel accessed
// - Write index first, then read that entry
// - Route enable reads old value until synchronized
module gcrc_top #(
    parameter NUM_CHAN    = 37,
    parameter NUM_GEN     = 9,
    parameter SYNC_CYCLES = `GCRC_SYNC_CYCLES
) (
    input  wire                        ref_clk,
    input  wire                        sys_rst,
    input  wire                        psel,
    input  wire                        penable,
    input  wire                        pwrite,
    input  wire [`GCRC_ADDR_W-1:0]     paddr,
    input  wire [31:0]                 pwdata,
    input  wire [3:0]                  pstrb,
    output wire                        pready,
    output wire [31:0]                 prdata,
    output wire                        pslverr,
    input  wire                        standbyReq,
    input  wire [NUM_CHAN-1:0]         periphClkReq,
    input  wire                        srcReady,
    input  wire [NUM_GEN-1:0]          genClkIn,
    output wire                        srcWakeReq,
    output wire [`GCRC_SRC_W-1:0]      srcWakeSel,
    output wire [NUM_GEN-1:0]          genRunEn,
    output wire [NUM_GEN*16-1:0]       genDivOut,
    output wire [NUM_CHAN-1:0]         chanClkEn,
    output wire [NUM_CHAN*4-1:0]       chanUnitSel,
    output wire [NUM_GEN-1:0]          clockOutPin,
    output wire [NUM_GEN-1:0]          clockOutEn
);

    localparam [2:0] ST_IDLE    = 3'd0;
    localparam [2:0] ST_WAKE    = 3'd1;
    localparam [2:0] ST_GEN_ON  = 3'd2;
    localparam [2:0] ST_CHAN_ON = 3'd3;
    localparam [2:0] ST_DELIVER = 3'd4;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [NUM_CHAN*4-1:0]      chanGen_q;
    reg [NUM_CHAN-1:0]        chanEn_q;
    reg [NUM_CHAN-1:0]        chanLock_q;
    reg [NUM_GEN*6-1:0]       genCfg_q;
    reg [NUM_GEN*5-1:0]       genSrc_q;
    reg [NUM_GEN*16-1:0]      divider_unit_ratio_reg_q;
    reg [5:0]                 clkIdx_q;
    reg [3:0]                 genIdx_q;
    reg [3:0]                 divIdx_q;
    reg                       srst_q;
    reg                       pendEn_q;
    reg                       pendEnVal_q;
    reg [5:0]                 pendChan_q;
    reg [31:0]                prdata_q;
    reg [2:0]                 state_q;
    reg [5:0]                 svcChan_q;
    reg [3:0]                 svcGen_q;
    reg [NUM_CHAN-1:0]        chanClkEn_q;
    reg [NUM_GEN-1:0]         genRunEn_q;
    wire [NUM_GEN-1:0]        genLocked;
    wire                      busy;
    wire                      syncDone;
    wire                      standby;
    wire                      srcReadyS;
    wire [NUM_CHAN-1:0]       reqS;

    function [31:0] mergeWord;
        input [31:0] oldW;
        input [31:0] newW;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                mergeWord[k*8 +: 8] = strb[k] ? newW[k*8 +: 8] : oldW[k*8 +: 8];
            end
        end
    endfunction

    function [5:0] firstSet;
        input [NUM_CHAN-1:0] v;
        integer k;
        begin
            firstSet = 6'h00;
            for (k = NUM_CHAN - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    firstSet = k[5:0];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin inputs
    // ----------------------------------------------------------------
    gcrc_sync3 #(.WIDTH(NUM_CHAN + 2)) uSync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn ({standbyReq, srcReady, periphClkReq}),
        .syncOut ({standby, srcReadyS, reqS})
    );

    // ----------------------------------------------------------------
    // Lock fan-in per unit
    // ----------------------------------------------------------------
    genvar g;
    genvar c;
    generate
        for (g = 0; g < NUM_GEN; g = g + 1) begin : gLock
            localparam [3:0] GID = g;
            wire [NUM_CHAN-1:0] hit;
            for (c = 0; c < NUM_CHAN; c = c + 1) begin : gCh
                assign hit[c] = chanLock_q[c] & (chanGen_q[c*4 +: 4] == GID);
            end
            if (g == 0) begin : gZero
                assign genLocked[g] = 1'b0;
            end else begin : gOther
                assign genLocked[g] = |hit;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire [3:0] regIdx    = paddr[5:2];
    wire       upperZero = (paddr[`GCRC_ADDR_W-1:6] == {(`GCRC_ADDR_W-6){1'b0}}) &&
                           (paddr[1:0] == 2'b00);
    wire       hitCtrl   = upperZero && (regIdx == `GCRC_IDX_CTRL);
    wire       hitStat   = upperZero && (regIdx == `GCRC_IDX_STATUS);
    wire       hitClk    = upperZero && (regIdx == `GCRC_IDX_CLOCK_ROUTE_REG);
    wire       hitGCtl   = upperZero && (regIdx == `GCRC_IDX_DIVIDER_UNIT_SETUP_REG);
    wire       hitGDiv   = upperZero && (regIdx == `GCRC_IDX_DIVIDER_UNIT_RATIO_REG);
    wire       mapped    = hitCtrl | hitStat | hitClk | hitGCtl | hitGDiv;
    wire       clkCfgWr  = hitClk & pstrb[1];
    wire       isSyncWr  = psel & pwrite & (hitCtrl | hitGCtl | hitGDiv | clkCfgWr);

    assign pready  = ~(isSyncWr & busy);
    assign pslverr = psel & penable & ~mapped;
    wire   wrEn    = psel & penable & pready & pwrite & mapped;

    // Index taken from the same write when its low byte is present
    wire [5:0] wrChan  = pstrb[0] ? pwdata[5:0] : clkIdx_q;
    wire [3:0] wrGen   = pstrb[0] ? pwdata[3:0] : genIdx_q;
    wire [3:0] wrDiv   = pstrb[0] ? pwdata[3:0] : divIdx_q;
    wire       chanOk  = ({26'h0, wrChan} < NUM_CHAN);
    wire       genOk   = ({28'h0, wrGen} < NUM_GEN);
    wire       divOk   = ({28'h0, wrDiv} < NUM_GEN);

    wire [31:0] genCtlOld = {10'h000, genCfg_q[wrGen*6 +: 6], 3'h0,
                             genSrc_q[wrGen*5 +: 5], 4'h0, wrGen};
    wire [31:0] genDivOld = {8'h00, divider_unit_ratio_reg_q[wrDiv*16 +: 16], 4'h0, wrDiv};
    wire [31:0] genCtlNew = mergeWord(genCtlOld, pwdata, pstrb);
    wire [31:0] genDivNew = mergeWord(genDivOld, pwdata, pstrb);

    wire doCtrl = wrEn & hitCtrl & pstrb[0] & pwdata[`GCRC_SRST_BIT];
    wire doClk  = wrEn & clkCfgWr & chanOk & ~chanLock_q[wrChan];
    wire doGCtl = wrEn & hitGCtl & genOk & ~genLocked[wrGen];
    wire doGDiv = wrEn & hitGDiv & divOk & ~genLocked[wrDiv];
    wire syncStart = wrEn & isSyncWr;

    gcrc_sync_engine #(.SYNC_CYCLES(SYNC_CYCLES)) uEngine (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .start   (syncStart),
        .busy    (busy),
        .done    (syncDone)
    );

    // ----------------------------------------------------------------
    // Register read, captured in the setup cycle
    // ----------------------------------------------------------------
    wire [5:0]  rdChan = ({26'h0, clkIdx_q} < NUM_CHAN) ? clkIdx_q : 6'h00;
    wire        rdChOk = ({26'h0, clkIdx_q} < NUM_CHAN);
    wire        rdGOk  = ({28'h0, genIdx_q} < NUM_GEN);
    wire        rdDOk  = ({28'h0, divIdx_q} < NUM_GEN);
    reg  [31:0] readWord;

    always @* begin
        readWord = 32'h0000_0000;
        if (hitCtrl) begin
            readWord[`GCRC_SRST_BIT] = srst_q;
        end else if (hitStat) begin
            readWord[`GCRC_BUSY_BIT] = busy;
        end else if (hitClk) begin
            readWord[5:0] = clkIdx_q;
            if (rdChOk) begin
                readWord[`GCRC_LOCK_BIT] = chanLock_q[rdChan];
                readWord[`GCRC_EN_BIT]   = chanEn_q[rdChan];
                readWord[11:8]           = chanGen_q[rdChan*4 +: 4];
            end
        end else if (hitGCtl) begin
            readWord[3:0] = genIdx_q;
            if (rdGOk) begin
                readWord[12:8]  = genSrc_q[genIdx_q*5 +: 5];
                readWord[21:16] = genCfg_q[genIdx_q*6 +: 6];
            end
        end else if (hitGDiv) begin
            readWord[3:0] = divIdx_q;
            if (rdDOk) begin
                readWord[23:8] = divider_unit_ratio_reg_q[divIdx_q*16 +: 16];
            end
        end
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= readWord;
        end
    end
    assign prdata = prdata_q;

    // ----------------------------------------------------------------
    // Register writes and soft reset
    // ----------------------------------------------------------------
    integer i;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanGen_q   <= {NUM_CHAN*4{1'b0}};
            chanEn_q    <= {NUM_CHAN{1'b0}};
            chanLock_q  <= {NUM_CHAN{1'b0}};
            genCfg_q    <= {NUM_GEN{`GCRC_CFG_RST}};
            genSrc_q    <= {NUM_GEN{`GCRC_SRC_RST}};
            divider_unit_ratio_reg_q    <= {NUM_GEN{`GCRC_DIV_RST}};
            clkIdx_q    <= 6'h00;
            genIdx_q    <= 4'h0;
            divIdx_q    <= 4'h0;
            srst_q      <= 1'b0;
            pendEn_q    <= 1'b0;
            pendEnVal_q <= 1'b0;
            pendChan_q  <= 6'h00;
        end else if (syncDone && srst_q) begin
            // Locked routes and their units other than unit zero survive; power reset only
            for (i = 0; i < NUM_CHAN; i = i + 1) begin
                if (!chanLock_q[i]) begin
                    chanGen_q[i*4 +: 4] <= 4'h0;
                    chanEn_q[i]         <= 1'b0;
                end
            end
            for (i = 0; i < NUM_GEN; i = i + 1) begin
                if (!genLocked[i]) begin
                    genCfg_q[i*6 +: 6]   <= `GCRC_CFG_RST;
                    genSrc_q[i*5 +: 5]   <= `GCRC_SRC_RST;
                    divider_unit_ratio_reg_q[i*16 +: 16] <= `GCRC_DIV_RST;
                end
            end
            clkIdx_q <= 6'h00;
            genIdx_q <= 4'h0;
            divIdx_q <= 4'h0;
            srst_q   <= 1'b0;
            pendEn_q <= 1'b0;
        end else begin
            if (syncDone && pendEn_q) begin
                chanEn_q[pendChan_q] <= pendEnVal_q;
                pendEn_q             <= 1'b0;
            end
            if (doCtrl) begin
                srst_q <= 1'b1;
            end
            if (wrEn && hitClk && pstrb[0]) begin
                clkIdx_q <= pwdata[5:0];
            end
            if (doClk) begin
                chanGen_q[wrChan*4 +: 4] <= pwdata[11:8];
                chanLock_q[wrChan]       <= pwdata[`GCRC_LOCK_BIT];
                pendEn_q                 <= 1'b1;
                pendEnVal_q              <= pwdata[`GCRC_EN_BIT];
                pendChan_q               <= wrChan;
            end
            if (wrEn && hitGCtl && pstrb[0]) begin
                genIdx_q <= pwdata[3:0];
            end
            if (doGCtl) begin
                genSrc_q[wrGen*5 +: 5] <= genCtlNew[12:8];
                genCfg_q[wrGen*6 +: 6] <= genCtlNew[21:16];
            end
            if (wrEn && hitGDiv && pstrb[0]) begin
                divIdx_q <= pwdata[3:0];
            end
            if (doGDiv) begin
                divider_unit_ratio_reg_q[wrDiv*16 +: 16] <= genDivNew[23:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // Sleep-time clock requests
    // ----------------------------------------------------------------
    wire [NUM_CHAN-1:0] liveReq = reqS & chanEn_q;
    reg  [2:0]          state_d;

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (standby && (|liveReq)) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (srcReadyS) begin
                    state_d = ST_GEN_ON;
                end
            end
            ST_GEN_ON: begin
                state_d = ST_CHAN_ON;
            end
            ST_CHAN_ON: begin
                state_d = ST_DELIVER;
            end
            ST_DELIVER: begin
                if (!standby || !reqS[svcChan_q]) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= ST_IDLE;
            svcChan_q <= 6'h00;
            svcGen_q  <= 4'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_IDLE && state_d == ST_WAKE) begin
                svcChan_q <= firstSet(liveReq);
                svcGen_q  <= chanGen_q[firstSet(liveReq)*4 +: 4];
            end
        end
    end

    wire svcGenOk = ({28'h0, svcGen_q} < NUM_GEN);
    assign srcWakeReq = (state_q != ST_IDLE);
    assign srcWakeSel = svcGenOk ? genSrc_q[svcGen_q*5 +: 5] : 5'h00;

    // ----------------------------------------------------------------
    // Clock enables and output pins
    // ----------------------------------------------------------------
    wire svcUnitUp = (state_q == ST_GEN_ON) || (state_q == ST_CHAN_ON) ||
                     (state_q == ST_DELIVER);
    wire svcRouteUp = (state_q == ST_DELIVER);

    generate
        for (g = 0; g < NUM_GEN; g = g + 1) begin : gUnit
            localparam [3:0] UID = g;
            wire en   = genCfg_q[g*6 + `GCRC_CFG_GENEN];
            wire off_level_select  = genCfg_q[g*6 + `GCRC_CFG_OOV];
            wire oe   = genCfg_q[g*6 + `GCRC_CFG_OE];
            wire keep = genCfg_q[g*6 + `GCRC_CFG_KEEP];
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    genRunEn_q[g] <= 1'b0;
                end else begin
                    genRunEn_q[g] <= en & (~standby | keep |
                                     (svcUnitUp & (svcGen_q == UID)));
                end
            end
            // Clock pass-through; plain combinational mux, so freezing is not glitch free as the enable changes
            assign clockOutPin[g] = (oe & en & genRunEn_q[g] & (~standby | keep)) ?
                                    genClkIn[g] : off_level_select;
            assign clockOutEn[g]  = oe;
        end
        for (c = 0; c < NUM_CHAN; c = c + 1) begin : gRoute
            localparam [5:0] CID = c;
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    chanClkEn_q[c] <= 1'b0;
                end else begin
                    chanClkEn_q[c] <= chanEn_q[c] &
                                      (~standby | (svcRouteUp & (svcChan_q == CID)));
                end
            end
        end
    endgenerate

    assign genRunEn    = genRunEn_q;
    assign chanClkEn   = chanClkEn_q;
    assign chanUnitSel = chanGen_q;
    assign genDivOut   = divider_unit_ratio_reg_q;

endmodule // gcrc_top

// >>> verilog/gcrc_consts.vh
`ifndef GCRC_CONSTS_VH
`define GCRC_CONSTS_VH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define GCRC_IDX_CTRL        4'h0
`define GCRC_IDX_STATUS      4'h1
`define GCRC_IDX_CLOCK_ROUTE_REG     4'h2
`define GCRC_IDX_DIVIDER_UNIT_SETUP_REG     4'h4
`define GCRC_IDX_DIVIDER_UNIT_RATIO_REG      4'h8
`define GCRC_ADDR_W          12

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GCRC_SRST_BIT        0
`define GCRC_BUSY_BIT        7
`define GCRC_LOCK_BIT        15
`define GCRC_EN_BIT          14
`define GCRC_SEL_LSB         8
`define GCRC_SEL_W           4
`define GCRC_TGT_W           6
`define GCRC_UNIT_W          4
`define GCRC_SRC_LSB         8
`define GCRC_SRC_W           5
`define GCRC_CFG_LSB         16
`define GCRC_CFG_W           6
`define GCRC_CFG_GENEN       0
`define GCRC_CFG_IDC         1
`define GCRC_CFG_OOV         2
`define GCRC_CFG_OE          3
`define GCRC_CFG_DIVSEL      4
`define GCRC_CFG_KEEP        5
`define GCRC_DIV_LSB         8
`define GCRC_DIV_W           16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GCRC_CTRL_RST        8'h00
`define GCRC_STATUS_RST      8'h00
`define GCRC_CLOCK_ROUTE_REG_RST     16'h0000
`define GCRC_CFG_RST         6'h00
`define GCRC_SRC_RST         5'h00
`define GCRC_DIV_RST         16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GCRC_CLK_PERIOD_NS   25
`define GCRC_SYNC_NS         100
`define GCRC_SYNC_CYCLES     ((`GCRC_SYNC_NS + `GCRC_CLK_PERIOD_NS - 1) / `GCRC_CLK_PERIOD_NS)

`endif

// >>> verilog/gcrc_sync3.v
`timescale 1ns/10ps

module gcrc_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            // Stage one feeds stage two only
            always @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_q  <= 1'b0;
                    s2_q  <= 1'b0;
                    s3_q  <= 1'b0;
                    out_q <= 1'b0;
                end else begin
                    s1_q <= asyncIn[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign syncOut[i] = out_q;
        end
    endgenerate

endmodule // gcrc_sync3

// >>> verilog/gcrc_sync_engine.v
`timescale 1ns/10ps

module gcrc_sync_engine #(
    parameter SYNC_CYCLES = 4
) (
    input  wire ref_clk,
    input  wire sys_rst,
    input  wire start,
    output wire busy,
    output wire done
);

    // ----------------------------------------------------------------
    // Round trip into the clock domains, modelled as a fixed count
    // ----------------------------------------------------------------
    reg        busy_q;
    reg [7:0]  cnt_q;
    reg        done_q;

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q  <= 8'h00;
            end else if (busy_q) begin
                if (cnt_q == SYNC_CYCLES[7:0] - 8'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;

endmodule // gcrc_sync_engine

// >>> verif/gcrc_sva.sv
`timescale 1ns/10ps
`include "gcrc_consts.vh"
module gcrc_sva #(
    parameter NUM_CHAN = 37,
    parameter NUM_GEN  = 9
) (
    input wire                    ref_clk,
    input wire                    sys_rst,
    input wire                    psel,
    input wire                    penable,
    input wire                    pwrite,
    input wire [`GCRC_ADDR_W-1:0] paddr,
    input wire                    pready,
    input wire                    pslverr,
    input wire                    srcWakeReq,
    input wire                    srcReady,
    input wire [NUM_GEN-1:0]      genRunEn,
    input wire [NUM_CHAN-1:0]     chanClkEn
);
    // ------------------------
    // Bus and wake checks
    // ------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire acc   = psel && penable;
    wire ctlWr = psel && pwrite && paddr == 12'h000;
    chk_stall_busy: assert property (
        acc && pready && ctlWr ##1 !psel ##1 ctlWr && !penable |=> !pready) else $error("no stall");
    chk_stall_bound: assert property (
        acc && !pready |-> ##[1:5] pready) else $error("stall too long");
    chk_idle_ready: assert property (!psel |-> pready) else $error("idle not ready");
    chk_read_nowait: assert property (
        acc && !pwrite |-> pready) else $error("read stalled");
    chk_unmapped_err: assert property (
        acc && paddr == 12'h00c |-> pslverr) else $error("no error");
    chk_mapped_ok: assert property (
        acc && paddr == 12'h008 |-> !pslverr) else $error("false error");
    chk_power_reset: assert property (
        $fell(sys_rst) |-> chanClkEn == '0 && genRunEn == '0) else $error("reset state");
    chk_wake_wait: assert property (
        srcWakeReq && !srcReady |=> $stable(genRunEn)) else $error("unit before source");
    cover property (acc && !pready);
    cover property ($rose(srcWakeReq));
    cover property (srcWakeReq && srcReady);
endmodule // gcrc_sva

bind gcrc_top gcrc_sva #(.NUM_CHAN(NUM_CHAN), .NUM_GEN(NUM_GEN)) i_gcrc_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .srcWakeReq(srcWakeReq),
    .srcReady(srcReady), .genRunEn(genRunEn), .chanClkEn(chanClkEn));

// >>> verif/gcrc_partner.sv
`timescale 1ns/10ps
module gcrc_partner #(
    parameter NUM_CHAN = 37,
    parameter NUM_GEN  = 9
) (
    input  wire                ref_clk,
    input  wire                sys_rst,
    input  wire [NUM_CHAN-1:0] wantClk,
    input  wire [7:0]          wakeDelay,
    input  wire                srcWakeReq,
    output wire [NUM_CHAN-1:0] periphClkReq,
    output wire                srcReady,
    output wire [NUM_GEN-1:0]  genClkIn
);
    // ------------------------
    // Peripherals and source
    // ------------------------
    reg [7:0]         wakeCnt_q;
    reg [NUM_GEN-1:0] genPhase_q;
    assign periphClkReq = wantClk;
    // Late source answer, so the wake order is visible
    assign srcReady     = srcWakeReq && wakeCnt_q >= wakeDelay;
    assign genClkIn     = genPhase_q;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wakeCnt_q  <= 8'h00;
            genPhase_q <= {NUM_GEN{1'b0}};
        end else begin
            wakeCnt_q  <= srcWakeReq ? wakeCnt_q + {7'h00, wakeCnt_q != 8'hff} : 8'h00;
            genPhase_q <= genPhase_q + 1'b1;
        end
    end
endmodule // gcrc_partner

// >>> verif/tb_gcrc_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin numErrors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_gcrc_top;
    localparam [11:0] ACTL = 12'h000, AST = 12'h004, ART = 12'h008, ASET = 12'h010, ADIV = 12'h020;
    reg          ref_clk = 1'b0, sys_rst = 1'b1, standbyReq = 1'b0;
    reg          psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    reg  [11:0]  paddr = 12'h000;
    reg  [31:0]  pwdata = 32'h0, rd;
    reg  [3:0]   pstrb = 4'h0;
    reg  [36:0]  wantClk = 37'h0;
    wire         pready, pslverr, srcReady, srcWakeReq;
    wire [31:0]  prdata;
    wire [8:0]   genClkIn, genRunEn, clockOutPin;
    wire [36:0]  periphClkReq, chanClkEn;
    wire [143:0] genDivOut;
    wire [147:0] chanUnitSel;
    int          numErrors = 0, nChecks = 0, waits, k;
    gcrc_top #(.SYNC_CYCLES(4)) i_gcrc_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .standbyReq(standbyReq),
        .periphClkReq(periphClkReq), .srcReady(srcReady), .genClkIn(genClkIn),
        .srcWakeReq(srcWakeReq), .srcWakeSel(), .genRunEn(genRunEn), .genDivOut(genDivOut),
        .chanClkEn(chanClkEn), .chanUnitSel(chanUnitSel), .clockOutPin(clockOutPin),
        .clockOutEn());
    gcrc_partner i_gcrc_partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .wantClk(wantClk),
        .wakeDelay(8'h0a), .srcWakeReq(srcWakeReq), .periphClkReq(periphClkReq),
        .srcReady(srcReady), .genClkIn(genClkIn));
    initial forever #12.5 ref_clk = ~ref_clk;
    // ------------------------
    // Bus tasks
    // ------------------------
    task give_verdict;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Every wait on a signal runs through here, so a hang ends in the verdict
    task tick;
        @(negedge ref_clk);
        k++;
        if (k > 300) begin
            numErrors++;
            give_verdict;
        end
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] d, input [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        tick;
        while (pready !== 1'b1) tick;
        waits = k - 1;
        rd = prdata;
        er = pslverr;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge ref_clk);
    endtask
    task wr(input [11:0] a, input [31:0] d, input [3:0] s);
        apb(1'b1, a, d, s);
    endtask
    task rdc(input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        `CHK(rd, e)
    endtask
    // ------------------------
    // Scenarios
    // ------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdc(AST, 32'h0);
        rdc(ART, 32'h0);
        rdc(12'h00c, 32'h0);
        `CHK(er, 1'b1)
        wr(ACTL, 32'h0, 4'h1);
        apb(1'b0, AST, 32'h0, 4'h0);
        `CHK(rd[7], 1'b1)
        wr(ACTL, 32'h0, 4'h1);
        wr(ACTL, 32'h0, 4'h1);
        `CHK(waits > 0, 1'b1)
        repeat (6) @(negedge ref_clk);
        rdc(AST, 32'h0);
        rdc(ACTL, 32'h0);
        $display("test sync done");
        wr(ADIV, 32'h0012_3403, 4'h7);
        wr(ADIV, 32'h0000_5502, 4'h7);
        wr(ART, 32'h0000_4203, 4'h3);
        wr(ART, 32'h0000_c305, 4'h3);
        wr(ACTL, 32'h1, 4'h1);
        rdc(ACTL, 32'h1);
        repeat (8) @(negedge ref_clk);
        rdc(ACTL, 32'h0);
        `CHK(genDivOut[63:32], 32'h1234_0000)
        `CHK({chanClkEn[5], chanClkEn[3]}, 2'b10)
        wr(ART, 32'h5, 4'h1);
        rdc(ART, 32'h0000_c305);
        $display("test soft reset done");
        wr(ART, 32'h0000_0005, 4'h3);
        wr(ADIV, 32'h0099_9903, 4'h7);
        repeat (6) @(negedge ref_clk);
        `CHK({chanClkEn[5], genDivOut[63:48]}, 17'h11234)
        wr(ART, 32'h0000_8006, 4'h3);
        wr(ADIV, 32'h0077_7700, 4'h7);
        `CHK(genDivOut[15:0], 16'h7777)
        for (int g = 0; g < 9; g++) begin
            wr(ART, {20'h0, g[3:0], 8'h07}, 4'h3);
            `CHK(chanUnitSel[31:28], g[3:0])
        end
        $display("test lock done");
        wr(ASET, 32'h0029_0001, 4'h7);
        wr(ASET, 32'h000d_0002, 4'h7);
        wr(ART, 32'h0000_4208, 4'h3);
        `CHK(chanClkEn[8], 1'b0)
        repeat (6) @(negedge ref_clk);
        `CHK(chanClkEn[8], 1'b1)
        @(posedge ref_clk);
        standbyReq <= 1'b1;
        wantClk[8] <= 1'b1;
        k = 0;
        while (srcWakeReq !== 1'b1) tick;
        `CHK(genRunEn[2], 1'b0)
        while (genRunEn[2] !== 1'b1) tick;
        repeat (3) tick;
        `CHK({chanClkEn[8], srcReady}, 2'b11)
        repeat (2) begin
            tick;
            `CHK(clockOutPin[1], genClkIn[1])
        end
        `CHK(clockOutPin[2], 1'b1)
        @(posedge ref_clk);
        standbyReq <= 1'b0;
        wantClk <= 37'h0;
        $display("test sleep done");
        give_verdict;
    end
endmodule // tb_gcrc_top
